/* File: shared/fast_counter_pkg.sv */
// Constants shared by the fast counter and interrupt input block.
package fast_counter_pkg;
   localparam int          COUNT_W         = 16;
   localparam logic [15:0] COUNT_RESET     = 16'h0000;
   localparam logic [15:0] CMP_FORBIDDEN   = 16'h0001;
   localparam logic [15:0] CMP_LOW_LIMIT   = 16'h0002;
   localparam logic [15:0] ERR_NONE        = 16'h0000;
   localparam logic [15:0] ERR_BAD_COMPARE = 16'h00fd;
   localparam logic [7:0]  SRC_INPUT_ONE   = 8'h41;
   localparam logic [7:0]  SRC_INPUT_TWO   = 8'h42;
   localparam logic [7:0]  SRC_COMPARE_ONE = 8'h41;
   localparam logic [7:0]  SRC_COMPARE_TWO = 8'h42;
   localparam logic [7:0]  SRC_NONE        = 8'h00;

   typedef enum logic [2:0] {
      MODE_IDLE    = 3'b001,
      MODE_IRQ_IN  = 3'b010,
      MODE_COUNTER = 3'b100
   } share_mode_t;
endpackage

/* File: core/fast_counter_interrupt_inputs.sv */
// Fast up-counter and edge-triggered interrupt inputs sharing one resource.
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module fast_counter_interrupt_inputs (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst,
   // External terminals.
   input  wire logic        irq_in_one,
   input  wire logic        irq_in_two,
   input  wire logic        count_pulse,
   input  wire logic        count_enable_in,
   // Interrupt input gate call.
   input  wire logic        interrupt_input_gate_call,
   input  wire logic        gate_enable,
   // Counter setup call.
   input  wire logic        counter_setup_call,
   input  wire logic        setup_start,
   input  wire logic        setup_enable_input,
   input  wire logic        first_compare_irq_enable,
   input  wire logic        second_compare_irq_enable,
   input  wire logic [15:0] first_compare_value,
   input  wire logic [15:0] second_compare_value,
   // Counter read call.
   input  wire logic        counter_read_call,
   // Call results.
   output logic             call_done,
   output logic [15:0]      call_result_word,
   output logic             result_ok_bit,
   // Hardware interrupt request.
   output logic             hardware_irq_handler,
   output logic [7:0]       irq_source_code,
   // Status.
   output logic [15:0]      count_value,
   output logic             counter_running
);
   // Shared mode, run flag and count.
   fast_counter_pkg::share_mode_t mode_q;
   fast_counter_pkg::share_mode_t mode_d;
   logic                          run_q;
   logic                          run_d;
   logic [15:0]                   count_q;
   logic [15:0]                   count_d;
   // Counter configuration.
   logic [15:0]                   cmp1_q;
   logic [15:0]                   cmp1_d;
   logic [15:0]                   cmp2_q;
   logic [15:0]                   cmp2_d;
   logic                          use_en_q;
   logic                          use_en_d;
   logic                          ie1_q;
   logic                          ie1_d;
   logic                          ie2_q;
   logic                          ie2_d;
   // Terminal history for edge detection.
   logic                          one_q;
   logic                          one_d;
   logic                          two_q;
   logic                          two_d;
   logic                          pulse_q;
   logic                          pulse_d;
   // Call results.
   logic                          done_q;
   logic                          done_d;
   logic                          ok_q;
   logic                          ok_d;
   logic [15:0]                   result_q;
   logic [15:0]                   result_d;
   // Interrupt request.
   logic                          irq_q;
   logic                          irq_d;
   logic [7:0]                    src_q;
   logic [7:0]                    src_d;
   // Decoded events.
   logic                          edge_one;
   logic                          edge_two;
   logic                          step;
   logic                          bad_cmp;
   logic                          any_call;
   logic                          in_count_mode;
   logic                          below_limit;
   logic                          advance;
   logic [15:0]                   next_count;
   logic [15:0]                   cmp_word [2];
   logic [1:0]                    cmp_irq_en;
   logic [1:0]                    match;

   // ----------------------------------------------------------------------
   // Input edge detection
   // ----------------------------------------------------------------------
   // Input one idles high, so its history resets high and no false edge follows reset.
   always_comb begin
      one_d    = irq_in_one;
      two_d    = irq_in_two;
      pulse_d  = count_pulse;
      edge_one = one_q && !irq_in_one && !irq_in_two;
      edge_two = !two_q && irq_in_two;
      step     = !pulse_q && count_pulse && (!use_en_q || count_enable_in);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         one_q   <= 1'b1;
         two_q   <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         one_q   <= one_d;
         two_q   <= two_d;
         pulse_q <= pulse_d;
      end
   end

   // ----------------------------------------------------------------------
   // Call decode and results
   // ----------------------------------------------------------------------
   // Calls are served in priority setup, gate, read; a setup wins if two arrive together.
   always_comb begin
      any_call = counter_setup_call || interrupt_input_gate_call || counter_read_call;
      bad_cmp  = (first_compare_value == fast_counter_pkg::CMP_FORBIDDEN) ||
                 (second_compare_value == fast_counter_pkg::CMP_FORBIDDEN);
      done_d   = any_call;
      ok_d     = ok_q;
      result_d = result_q;
      if (counter_setup_call) begin
         if (bad_cmp) begin
            result_d = fast_counter_pkg::ERR_BAD_COMPARE;
            ok_d     = 1'b0;
         end else begin
            result_d = fast_counter_pkg::ERR_NONE;
            ok_d     = 1'b1;
         end
      end else if (interrupt_input_gate_call) begin
         result_d = fast_counter_pkg::ERR_NONE;
         ok_d     = 1'b1;
      end else if (counter_read_call) begin
         result_d = count_q;
         ok_d     = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         done_q   <= 1'b0;
         ok_q     <= 1'b1;
         result_q <= fast_counter_pkg::ERR_NONE;
      end else begin
         done_q   <= done_d;
         ok_q     <= ok_d;
         result_q <= result_d;
      end
   end

   // ----------------------------------------------------------------------
   // Counter configuration
   // ----------------------------------------------------------------------
   // A refused setup leaves the previous configuration in force.
   always_comb begin
      cmp1_d   = cmp1_q;
      cmp2_d   = cmp2_q;
      ie1_d    = ie1_q;
      ie2_d    = ie2_q;
      use_en_d = use_en_q;
      if (counter_setup_call && !bad_cmp) begin
         cmp1_d   = first_compare_value;
         cmp2_d   = second_compare_value;
         ie1_d    = first_compare_irq_enable;
         ie2_d    = second_compare_irq_enable;
         use_en_d = setup_enable_input;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmp1_q   <= 16'h0000;
         cmp2_q   <= 16'h0000;
         ie1_q    <= 1'b0;
         ie2_q    <= 1'b0;
         use_en_q <= 1'b0;
      end else begin
         cmp1_q   <= cmp1_d;
         cmp2_q   <= cmp2_d;
         ie1_q    <= ie1_d;
         ie2_q    <= ie2_d;
         use_en_q <= use_en_d;
      end
   end

   // ----------------------------------------------------------------------
   // Shared mode and counter
   // ----------------------------------------------------------------------
   // A zero limit means no ceiling; the count then wraps at ffff.
   always_comb begin
      next_count    = count_q + 16'h0001;
      in_count_mode = (mode_q == fast_counter_pkg::MODE_COUNTER);
      below_limit   = (cmp2_q == 16'h0000) || (count_q < cmp2_q);
      advance       = !any_call && in_count_mode && run_q && step && below_limit;
      mode_d        = mode_q;
      run_d         = run_q;
      count_d       = count_q;
      if (counter_setup_call) begin
         if (!bad_cmp) begin
            run_d   = setup_start;
            count_d = fast_counter_pkg::COUNT_RESET;
            // Claiming the counter releases the interrupt inputs.
            mode_d  = setup_start ? fast_counter_pkg::MODE_COUNTER
                                  : fast_counter_pkg::MODE_IDLE;
         end
      end else if (interrupt_input_gate_call) begin
         run_d  = 1'b0;
         mode_d = gate_enable ? fast_counter_pkg::MODE_IRQ_IN
                              : fast_counter_pkg::MODE_IDLE;
      end else if (advance) begin
         count_d = next_count;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q  <= fast_counter_pkg::MODE_IDLE;
         run_q   <= 1'b0;
         count_q <= fast_counter_pkg::COUNT_RESET;
      end else begin
         mode_q  <= mode_d;
         run_q   <= run_d;
         count_q <= count_d;
      end
   end

   // ----------------------------------------------------------------------
   // Compare matches
   // ----------------------------------------------------------------------
   // A zero compare value disables its match, so an unused compare never fires.
   always_comb begin
      cmp_word[0] = cmp1_q;
      cmp_word[1] = cmp2_q;
      cmp_irq_en  = {ie2_q, ie1_q};
   end

   for (genvar i = 0; i < 2; i++) begin : g_cmp
      assign match[i] = cmp_irq_en[i] && (next_count == cmp_word[i]) &&
                        (cmp_word[i] != 16'h0000);
   end

   // ----------------------------------------------------------------------
   // Interrupt request
   // ----------------------------------------------------------------------
   // No interrupt is judged in a cycle that carries a call; the call takes the slot.
   always_comb begin
      irq_d = 1'b0;
      src_d = src_q;
      if (!any_call) begin
         unique case (mode_q)
            fast_counter_pkg::MODE_IRQ_IN: begin
               if (edge_one) begin
                  irq_d = 1'b1;
                  src_d = fast_counter_pkg::SRC_INPUT_ONE;
               end else if (edge_two) begin
                  irq_d = 1'b1;
                  src_d = fast_counter_pkg::SRC_INPUT_TWO;
               end
            end
            fast_counter_pkg::MODE_COUNTER: begin
               // Compare two is checked last, so its code wins when both match.
               if (advance && match[0]) begin
                  irq_d = 1'b1;
                  src_d = fast_counter_pkg::SRC_COMPARE_ONE;
               end
               if (advance && match[1]) begin
                  irq_d = 1'b1;
                  src_d = fast_counter_pkg::SRC_COMPARE_TWO;
               end
            end
            fast_counter_pkg::MODE_IDLE: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_q <= 1'b0;
         src_q <= fast_counter_pkg::SRC_NONE;
      end else begin
         irq_q <= irq_d;
         src_q <= src_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   always_comb begin
      call_done            = done_q;
      call_result_word     = result_q;
      result_ok_bit        = ok_q;
      hardware_irq_handler = irq_q;
      irq_source_code      = src_q;
      count_value          = count_q;
      counter_running      = run_q;
   end
endmodule

/* File: verification/fast_counter_checker.sv */
// Assertion checker for the fast counter and interrupt input ports.
`timescale 1ns/100ps
module fast_counter_checker (
   input wire logic clk, rst, irq_in_one, irq_in_two, interrupt_input_gate_call, gate_enable,
   input wire logic counter_setup_call, setup_start, counter_read_call, result_ok_bit,
   input wire logic hardware_irq_handler, counter_running,
   input wire logic [15:0] first_compare_value, second_compare_value, call_result_word,
   input wire logic [15:0] count_value,
   input wire logic [7:0] irq_source_code
);
   // Mode and limit are shadowed here, since only the ports are visible.
   wire idle = !(counter_setup_call || interrupt_input_gate_call || counter_read_call);
   wire good = first_compare_value != 16'h0001 && second_compare_value != 16'h0001;
   logic gate_q;
   logic [15:0] lim_q;
   always_ff @(posedge clk) begin
      if (rst) gate_q <= 1'b0;
      else if (counter_setup_call && good) gate_q <= 1'b0;
      else if (interrupt_input_gate_call && !counter_setup_call) gate_q <= gate_enable;
      if (counter_setup_call && good) lim_q <= second_compare_value;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_refused_setup: assert property (counter_setup_call && !good |=>
      !result_ok_bit && call_result_word == 16'h00fd) else $error("refused setup wrong");
   a_start_zero: assert property (counter_setup_call && good |=> result_ok_bit &&
      count_value == 16'h0000 && counter_running == $past(setup_start)) else $error("bad start");
   a_count_up: assert property ($changed(count_value) |->
      count_value == $past(count_value) + 16'h0001 || count_value == 16'h0000) else $error("step");
   a_count_limit: assert property (counter_running && lim_q != 16'h0000 |->
      count_value <= lim_q) else $error("count above limit");
   a_read_count: assert property (counter_read_call && idle == 1'b0 &&
      !counter_setup_call && !interrupt_input_gate_call |=> call_result_word == $past(count_value))
      else $error("read value wrong");
   a_input_one: assert property (gate_q && idle && $fell(irq_in_one) && !irq_in_two |=>
      hardware_irq_handler && irq_source_code == 8'h41) else $error("input one missed");
   a_input_two: assert property (gate_q && idle && $rose(irq_in_two) && !$fell(irq_in_one)
      |=> hardware_irq_handler && irq_source_code == 8'h42) else $error("input two missed");
   a_one_ignored: assert property (gate_q && idle && $fell(irq_in_one) && irq_in_two &&
      !$rose(irq_in_two) && !counter_running |=> !hardware_irq_handler) else $error("not ignored");
   c_two: cover property (hardware_irq_handler && irq_source_code == 8'h42);
   c_limit: cover property (counter_running && count_value == lim_q);
   c_refused: cover property (!result_ok_bit);
endmodule
bind fast_counter_interrupt_inputs fast_counter_checker chk (.*);

/* File: verification/pulse_source.sv */
// Far-side model: a source of count pulses on the counting terminal.
`timescale 1ns/100ps
module pulse_source (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [7:0] pulses,
   output logic            count_pulse
);
   logic [8:0] left_q;
   // High one cycle, low one cycle, so every rise is a separate event.
   always_ff @(posedge clk) begin
      if (go) left_q <= {pulses, 1'b0};
      else if (left_q != 9'h000) left_q <= left_q - 9'h001;
   end
   assign count_pulse = left_q[0];
endmodule

/* File: verification/fast_counter_interrupt_inputs_tb_top.sv */
// Self-checking bench for the fast counter and interrupt inputs.
`timescale 1ns/100ps
module fast_counter_interrupt_inputs_tb_top;
   logic clk = 1'b0, rst = 1'b1, irq_in_one = 1'b1, irq_in_two = 1'b0, go = 1'b1;
   logic interrupt_input_gate_call = 1'b0, gate_enable = 1'b0, count_enable_in = 1'b1;
   logic counter_setup_call = 1'b0, setup_start = 1'b0, setup_enable_input = 1'b0;
   logic first_compare_irq_enable = 1'b0, second_compare_irq_enable = 1'b0;
   logic counter_read_call = 1'b0, call_done, result_ok_bit, hardware_irq_handler;
   logic counter_running, count_pulse;
   logic [15:0] first_compare_value = 16'h0000, second_compare_value = 16'h0000;
   logic [15:0] call_result_word, count_value;
   logic [7:0] irq_source_code, np = 8'h00;
   logic [7:0] seen[$];
   int errors = 0, total_checks = 0, cyc = 0;
   fast_counter_interrupt_inputs dut (.*);
   pulse_source far (.clk(clk), .go(go), .pulses(np), .count_pulse(count_pulse));
   initial forever #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (hardware_irq_handler === 1'b1) seen.push_back(irq_source_code);
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic call(input int k);
      @(posedge clk);
      {counter_setup_call, interrupt_input_gate_call, counter_read_call} <= 3'b100 >> k;
      @(posedge clk);
      {counter_setup_call, interrupt_input_gate_call, counter_read_call} <= 3'b000;
      #1 chk(call_done, 16'h0001);
   endtask
   task automatic setup(input logic s, e1, e2, input logic [15:0] a, b);
      @(posedge clk);
      {setup_start, first_compare_irq_enable, second_compare_irq_enable} <= {s, e1, e2};
      setup_enable_input <= s;
      first_compare_value <= a;
      second_compare_value <= b;
      call(0);
   endtask
   task automatic pins(input logic a, b);
      @(posedge clk);
      irq_in_one <= a;
      irq_in_two <= b;
      repeat (3) @(posedge clk);
   endtask
   task automatic gate(input logic e);
      @(posedge clk);
      gate_enable <= e;
      call(1);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      logic [15:0] a, b;
      logic [1:0] e;
      void'($urandom(32'ha867d7fc));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      go <= 1'b0;
      chk(result_ok_bit, 16'h0001);
      for (int k = 0; k < 2; k++) begin
         setup(1'b1, 1'b1, 1'b1, k ? 16'h0005 : 16'h0001, k ? 16'h0001 : 16'h0009);
         chk(call_result_word, 16'h00fd);
         chk(result_ok_bit, 16'h0000);
      end
      $display("test refused done");
      for (int k = 0; k < 3; k++) begin
         a = 16'h0002 + 16'($urandom % 20);
         b = a + 16'h0001 + 16'($urandom % 10);
         e = 2'($urandom);
         seen.delete();
         setup(1'b1, e[0], e[1], a, b);
         chk(count_value, 16'h0000);
         chk(counter_running, 16'h0001);
         @(posedge clk);
         np <= b[7:0] + 8'h03;
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         repeat (2 * int'(b) + 12) @(posedge clk);
         chk(count_value, b);
         chk(16'(seen.size()), 16'(e[0]) + 16'(e[1]));
         if (e[0]) chk(seen[0], 16'h0041);
         call(2);
         chk(call_result_word, b);
         $display("test counter %0d done", k);
      end
      gate(1'b1);
      chk(counter_running, 16'h0000);
      setup(1'b1, 1'b0, 1'b0, 16'h0002, 16'h0003);
      chk(counter_running, 16'h0001);
      setup(1'b0, 1'b0, 1'b0, 16'h0002, 16'h0003);
      chk(counter_running, 16'h0000);
      gate(1'b1);
      chk(counter_running, 16'h0000);
      seen.delete();
      pins(1'b0, 1'b0);
      pins(1'b1, 1'b1);
      pins(1'b0, 1'b1);
      chk(16'(seen.size()), 16'h0002);
      chk(seen[0], 16'h0041);
      chk(seen[1], 16'h0042);
      gate(1'b0);
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
      pins(1'b0, 1'b1);
      chk(16'(seen.size()), 16'h0002);
      $display("test inputs done");
      end_sim();
   end
endmodule
